// ### opadr_pkg.sv
// Constants and types for the operand addressing unit.
// Assumes an 8-bit core with 8-bit RAM and register-space addresses.
package opadr_pkg;

	// ----------------------------------------------------------------
	// Addressing modes, as handed over by the opcode decoder
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OPADR_SRC_INDEXED    = 4'h0,
		OPADR_DST_DIRECT     = 4'h1,
		OPADR_DST_INDEXED    = 4'h2,
		OPADR_DST_DIR_IMM    = 4'h3,
		OPADR_DST_IDX_IMM    = 4'h4,
		OPADR_MEM_TO_MEM     = 4'h5,
		OPADR_SRC_INDIRECT   = 4'h6,
		OPADR_DST_INDIRECT   = 4'h7
	} opadr_mode_e;

	// Register selector for the register operand
	localparam logic SEL_ACC = 1'b0;
	localparam logic SEL_IDX = 1'b1;

	// Instruction lengths in bytes
	localparam logic [1:0] LEN_TWO   = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Pointer step for post increment
	localparam logic [7:0] PTR_STEP = 8'h01;

	// ----------------------------------------------------------------
	// Sequencer states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_PTR   = 5'b00010,
		ST_DATA  = 5'b00100,
		ST_INC   = 5'b01000,
		ST_DONE  = 5'b10000
	} opadr_state_e;

endpackage : opadr_pkg

// ### opadr_unit.sv
// Operand addressing unit: turns a decoded mode and operand bytes into
// source/destination selections, RAM addresses and pointer sequencing.
// Assumes fetch gives stable mode and operands while start is high for one
// cycle, and that RAM reads return data in the cycle after the read strobe.
//
// Summary of operation
// RL1: Source indexed adds operand to index; result to A or X; two bytes.
// RL2: Source indexed arithmetic takes second source from opcode-chosen A or X.
// RL3: Destination direct writes operand address; source A or X; two bytes.
// RL4: Destination indexed address is operand plus X; source A only; two bytes.
// RL5: Direct immediate: operand one is destination, operand two immediate; three bytes.
// RL6: Indexed immediate: operand one plus X destination, operand two immediate.
// RL7: Memory-to-memory move copies RAM at operand two to operand one.
// RL8: Indirect source reads pointer, loads A from it, increments the pointer.
// RL9: Indirect destination reads pointer, stores A there, increments the pointer.
// RL10: Indexed addresses are 8-bit sums, carry out of bit seven dropped.
`timescale 1ns/1ps
`default_nettype none

module opadr_unit
(
	input  wire logic                   sys_clk,
	input  wire logic                   resetn,
	input  wire logic                   start,
	input  wire opadr_pkg::opadr_mode_e mode,
	input  wire logic                   regSel,
	input  wire logic                   isArith,
	input  wire logic                   isMove,
	input  wire logic                   regSpace,
	input  wire logic [7:0]             operand1,
	input  wire logic [7:0]             operand2,
	input  wire logic [7:0]             accValue,
	input  wire logic [7:0]             idxValue,
	input  wire logic [7:0]             ramRdData,
	output logic                        busy,
	output logic                        done,
	output logic                        illegal,
	output logic [1:0]                  instrLen,
	output logic [7:0]                  srcAddr,
	output logic                        srcValid,
	output logic                        srcRegSpace,
	output logic [7:0]                  dstAddr,
	output logic                        dstValid,
	output logic                        dstRegSpace,
	output logic                        immValid,
	output logic [7:0]                  immValue,
	output logic                        srcReg,
	output logic                        srcRegValid,
	output logic                        resultReg,
	output logic                        resultToReg,
	output logic                        dstReadValid,
	output logic                        ramRd,
	output logic                        ramWr,
	output logic [7:0]                  ramAddr,
	output logic [7:0]                  ramWrData,
	output logic                        accLoad,
	output logic [7:0]                  accLoadData
);
	import opadr_pkg::*;

	// ----------------------------------------------------------------
	// Address arithmetic
	// ----------------------------------------------------------------

	// Wraps within the page; the carry is dropped on purpose
	logic [7:0] idxSum;
	assign idxSum = 8'(operand1 + idxValue); // [RL10]

	// ----------------------------------------------------------------
	// Decode registers, captured on start
	// ----------------------------------------------------------------

	// Outputs are held until the next start so execute can use them
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			instrLen     <= LEN_TWO;
			srcAddr      <= RST_BYTE;
			srcValid     <= 1'b0;
			srcRegSpace  <= 1'b0;
			dstAddr      <= RST_BYTE;
			dstValid     <= 1'b0;
			dstRegSpace  <= 1'b0;
			immValid     <= 1'b0;
			immValue     <= RST_BYTE;
			srcReg       <= SEL_ACC;
			srcRegValid  <= 1'b0;
			resultReg    <= SEL_ACC;
			resultToReg  <= 1'b0;
			dstReadValid <= 1'b0;
			illegal      <= 1'b0;
		end
		else if (start)
		begin
			instrLen     <= LEN_TWO;
			srcAddr      <= RST_BYTE;
			srcValid     <= 1'b0;
			srcRegSpace  <= regSpace;
			dstAddr      <= RST_BYTE;
			dstValid     <= 1'b0;
			dstRegSpace  <= regSpace;
			immValid     <= 1'b0;
			immValue     <= RST_BYTE;
			srcReg       <= regSel;
			srcRegValid  <= 1'b0;
			resultReg    <= regSel;
			resultToReg  <= 1'b0;
			dstReadValid <= 1'b0;
			illegal      <= 1'b0;
			case (mode)
				OPADR_SRC_INDEXED:
				begin
					srcAddr     <= idxSum;         // [RL1]
					srcValid    <= 1'b1;
					resultToReg <= 1'b1;           // [RL1]
					srcRegValid <= isArith;        // [RL2]
				end
				OPADR_DST_DIRECT:
				begin
					dstAddr      <= operand1;      // [RL3]
					dstValid     <= 1'b1;
					srcRegValid  <= 1'b1;          // [RL3]
					dstReadValid <= isArith;       // [RL3]
				end
				OPADR_DST_INDEXED:
				begin
					dstAddr      <= idxSum;        // [RL4]
					dstValid     <= 1'b1;
					srcReg       <= SEL_ACC;       // [RL4]
					srcRegValid  <= 1'b1;
					dstReadValid <= isArith;       // [RL4]
				end
				OPADR_DST_DIR_IMM:
				begin
					instrLen     <= LEN_THREE;     // [RL5]
					dstAddr      <= operand1;      // [RL5]
					dstValid     <= 1'b1;
					immValid     <= 1'b1;
					immValue     <= operand2;      // [RL5]
					dstReadValid <= isArith;       // [RL5]
				end
				OPADR_DST_IDX_IMM:
				begin
					instrLen     <= LEN_THREE;     // [RL6]
					dstAddr      <= idxSum;        // [RL6]
					dstValid     <= 1'b1;
					immValid     <= 1'b1;
					immValue     <= operand2;      // [RL6]
					dstReadValid <= isArith;
				end
				OPADR_MEM_TO_MEM:
				begin
					instrLen    <= LEN_THREE;      // [RL7]
					dstAddr     <= operand1;       // [RL7]
					srcAddr     <= operand2;
					srcValid    <= isMove;
					dstValid    <= isMove;
					srcRegSpace <= 1'b0;           // RAM only
					dstRegSpace <= 1'b0;
					illegal     <= !isMove;        // [RL7]
				end
				OPADR_SRC_INDIRECT:
				begin
					srcAddr     <= operand1;       // Pointer location
					srcRegSpace <= 1'b0;
					resultReg   <= SEL_ACC;        // [RL8]
					illegal     <= !isMove;
				end
				OPADR_DST_INDIRECT:
				begin
					dstAddr     <= operand1;       // Pointer location
					dstRegSpace <= 1'b0;
					srcReg      <= SEL_ACC;        // [RL9]
					srcRegValid <= 1'b1;
					illegal     <= !isMove;
				end
				default:
					illegal <= 1'b1;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Memory sequencer for move and indirect modes
	// ----------------------------------------------------------------

	opadr_state_e stateQ;
	opadr_state_e stateD;
	opadr_mode_e  modeQ;
	logic [7:0]   ptrAddrQ;
	logic [7:0]   ptrValQ;
	logic         seqMode;

	// Only these modes need RAM traffic; other modes finish at once
	assign seqMode = isMove && (mode == OPADR_MEM_TO_MEM || mode == OPADR_SRC_INDIRECT
		|| mode == OPADR_DST_INDIRECT);

	// Next state
	always_comb
	begin
		stateD = stateQ;
		case (stateQ)
			ST_IDLE: if (start) stateD = seqMode ? ST_PTR : ST_DONE;
			ST_PTR:  stateD = ST_DATA;
			ST_DATA: stateD = (modeQ == OPADR_MEM_TO_MEM) ? ST_DONE : ST_INC;
			ST_INC:  stateD = ST_DONE;
			ST_DONE: stateD = ST_IDLE;
			default: stateD = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			stateQ <= ST_IDLE;
		else
			stateQ <= stateD;
	end

	// Operands latched for the sequence
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			modeQ    <= OPADR_SRC_INDEXED;
			ptrAddrQ <= RST_BYTE;
		end
		else if (start && stateQ == ST_IDLE)
		begin
			modeQ    <= mode;
			ptrAddrQ <= (mode == OPADR_MEM_TO_MEM) ? operand2 : operand1;
		end
	end

	// Pointer kept from the first read for the write-back step
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			ptrValQ <= RST_BYTE;
		else if (stateQ == ST_DATA)
			ptrValQ <= ramRdData;
	end

	// RAM port: indirect modes read pointer, access through it, write back pointer+1
	always_comb
	begin
		ramRd     = 1'b0;
		ramWr     = 1'b0;
		ramAddr   = ptrAddrQ;
		ramWrData = RST_BYTE;
		case (stateQ)
			ST_PTR:
				ramRd = 1'b1;                  // [RL7] [RL8] [RL9]
			ST_DATA:
			begin
				if (modeQ == OPADR_MEM_TO_MEM)
				begin
					ramWr     = 1'b1;          // [RL7]
					ramAddr   = dstAddr;
					ramWrData = ramRdData;
				end
				else if (modeQ == OPADR_SRC_INDIRECT)
				begin
					ramRd   = 1'b1;            // [RL8]
					ramAddr = ramRdData;
				end
				else
				begin
					ramWr     = 1'b1;          // [RL9]
					ramAddr   = ramRdData;
					ramWrData = accValue;
				end
			end
			ST_INC:
			begin
				ramWr     = 1'b1;              // [RL8] [RL9]
				ramWrData = 8'(ptrValQ + PTR_STEP);
			end
			default: ramAddr = ptrAddrQ;
		endcase
	end

	// Accumulator load for indirect source, issued with done
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			accLoad     <= 1'b0;
			accLoadData <= RST_BYTE;
		end
		else
		begin
			accLoad <= (stateQ == ST_INC) && (modeQ == OPADR_SRC_INDIRECT); // [RL8]
			if (stateQ == ST_INC)
				accLoadData <= ramRdData;
		end
	end

	assign busy = (stateQ != ST_IDLE);
	assign done = (stateQ == ST_DONE);

endmodule : opadr_unit

`default_nettype wire

// ### opadr_unit_bench.sv
// Self-checking bench for the operand addressing unit.
// Assumes the monitor is bound in; the bench models the RAM itself.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module opadr_unit_bench;
	import opadr_pkg::*;

	logic        sys_clk, resetn, start, regSel, isArith, isMove, regSpace;
	opadr_mode_e mode;
	logic [7:0]  operand1, operand2, accValue, idxValue, ramRdData;
	logic        busy, done, illegal, srcReg, resultReg, dstReadValid, ramRd, ramWr;
	logic        srcValid, srcRegSpace, dstValid, dstRegSpace, immValid, srcRegValid;
	logic        resultToReg, accLoad;
	logic [1:0]  instrLen;
	logic [7:0]  srcAddr, dstAddr, immValue, ramAddr, ramWrData, accLoadData;
	logic [7:0]  mem [256];
	int          n_fail, compares;

	opadr_unit opadr_unit_inst (
		.sys_clk(sys_clk), .resetn(resetn), .start(start), .mode(mode),
		.regSel(regSel), .isArith(isArith), .isMove(isMove), .regSpace(regSpace),
		.operand1(operand1), .operand2(operand2), .accValue(accValue),
		.idxValue(idxValue), .ramRdData(ramRdData), .busy(busy), .done(done),
		.illegal(illegal), .instrLen(instrLen), .srcAddr(srcAddr),
		.srcValid(srcValid), .srcRegSpace(srcRegSpace), .dstAddr(dstAddr),
		.dstValid(dstValid), .dstRegSpace(dstRegSpace), .immValid(immValid),
		.immValue(immValue), .srcReg(srcReg), .srcRegValid(srcRegValid),
		.resultReg(resultReg), .resultToReg(resultToReg),
		.dstReadValid(dstReadValid), .ramRd(ramRd), .ramWr(ramWr),
		.ramAddr(ramAddr), .ramWrData(ramWrData), .accLoad(accLoad),
		.accLoadData(accLoadData));

	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// RAM model; idle read data inverts so a stale byte never passes
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			ramRdData <= 8'h00;
		else
		begin
			ramRdData <= ramRd ? mem[ramAddr] : ~ramRdData;
			if (ramWr) mem[ramAddr] <= ramWrData;
		end
	end

	task automatic issue(opadr_mode_e m, logic rs, ar, mv, logic [7:0] o1, o2);
		@(negedge sys_clk);
		mode = m;
		{regSel, isArith, isMove, operand1, operand2} = {rs, ar, mv, o1, o2};
		start = 1'b1;
		@(negedge sys_clk);
		start = 1'b0;
	endtask : issue

	// Bounded wait; caller's next issue adds the gap after done
	task automatic wait_done;
		int i;
		for (i = 0; i < 8 && done !== 1'b1; i++) @(negedge sys_clk);
		`CHK(done, 1'b1)
	endtask : wait_done

	task automatic t_src_idx;
		issue(OPADR_SRC_INDEXED, SEL_IDX, 1'b1, 1'b0, 8'h20, 8'h00);
		`CHK(srcAddr, 8'h10)
		`CHK(resultReg, SEL_IDX)
		`CHK(srcReg, SEL_IDX)
		`CHK({srcValid, resultToReg, srcRegValid, instrLen}, {3'b111, LEN_TWO})
		wait_done();
	endtask : t_src_idx

	task automatic t_dst;
		regSpace = 1'b1;
		issue(OPADR_DST_DIRECT, SEL_ACC, 1'b1, 1'b0, 8'h33, 8'h00);
		`CHK(dstAddr, 8'h33)
		`CHK(dstReadValid, 1'b1)
		`CHK({dstValid, dstRegSpace, srcRegValid, srcReg}, {3'b111, SEL_ACC})
		`CHK(instrLen, LEN_TWO)
		wait_done();
		issue(OPADR_DST_INDEXED, SEL_IDX, 1'b0, 1'b0, 8'hE0, 8'h00);
		`CHK(dstAddr, 8'hD0)
		`CHK(srcReg, SEL_ACC)
		`CHK({dstValid, srcRegValid, dstReadValid, instrLen}, {3'b110, LEN_TWO})
		wait_done();
	endtask : t_dst

	task automatic t_imm;
		issue(OPADR_DST_DIR_IMM, SEL_ACC, 1'b1, 1'b0, 8'h07, 8'h05);
		`CHK({dstAddr, immValue, instrLen}, {8'h07, 8'h05, LEN_THREE})
		`CHK({immValid, dstValid, dstReadValid}, 3'b111)
		wait_done();
		issue(OPADR_DST_IDX_IMM, SEL_ACC, 1'b0, 1'b0, 8'h08, 8'h06);
		`CHK({dstAddr, immValue, instrLen}, {8'hF8, 8'h06, LEN_THREE})
		`CHK({immValid, dstValid, dstReadValid}, 3'b110)
		wait_done();
	endtask : t_imm

	task automatic t_move;
		mem[8] = 8'h5A;
		issue(OPADR_MEM_TO_MEM, SEL_ACC, 1'b0, 1'b1, 8'h07, 8'h08);
		`CHK({busy, srcValid, dstValid, srcRegSpace, dstRegSpace}, 5'b11100)
		wait_done();
		`CHK(mem[7], 8'h5A)
		issue(OPADR_MEM_TO_MEM, SEL_ACC, 1'b0, 1'b0, 8'h09, 8'h08);
		`CHK(illegal, 1'b1)
		`CHK({srcValid, dstValid}, 2'b00)
		repeat (5) @(negedge sys_clk);
		`CHK(mem[9], 8'h00)
		regSpace = 1'b0;
		// Indirect modes without the move opcode must not touch the pointer
		issue(OPADR_DST_INDIRECT, SEL_ACC, 1'b0, 1'b0, 8'h08, 8'h00);
		`CHK(illegal, 1'b1)
		issue(OPADR_SRC_INDIRECT, SEL_ACC, 1'b0, 1'b0, 8'h08, 8'h00);
		`CHK(illegal, 1'b1)
		repeat (3) @(negedge sys_clk);
		`CHK(mem[8], 8'h5A)
	endtask : t_move

	task automatic t_indirect;
		mem[8] = 8'h40;
		mem[64] = 8'hC3;
		issue(OPADR_SRC_INDIRECT, SEL_ACC, 1'b0, 1'b1, 8'h08, 8'h00);
		wait_done();
		`CHK({accLoadData, mem[8]}, {8'hC3, 8'h41})
		`CHK(accLoad, 1'b1)
		accValue = 8'h99;
		issue(OPADR_DST_INDIRECT, SEL_ACC, 1'b0, 1'b1, 8'h08, 8'h00);
		wait_done();
		`CHK({mem[65], mem[8]}, {8'h99, 8'h42})
	endtask : t_indirect

	// Reset in mid-move: the cut sequence must never write its target
	task automatic t_reset;
		issue(OPADR_MEM_TO_MEM, SEL_ACC, 1'b0, 1'b1, 8'h0A, 8'h08);
		resetn = 1'b0;
		@(negedge sys_clk);
		`CHK({busy, ramWr, dstAddr, instrLen}, {2'b00, 8'h00, LEN_TWO})
		resetn = 1'b1;
		repeat (4) @(negedge sys_clk);
		`CHK(mem[10], 8'h00)
		issue(OPADR_DST_DIRECT, SEL_ACC, 1'b0, 1'b0, 8'h44, 8'h00);
		`CHK(dstAddr, 8'h44)
		wait_done();
	endtask : t_reset

	task automatic wrap_up;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up

	// Watchdog: the sequence needs well under a hundred cycles
	initial
	begin
		#(400 * 40);
		n_fail++;
		wrap_up();
	end

	initial
	begin
		{start, regSel, isArith, isMove, regSpace, resetn} = '0;
		mode = OPADR_SRC_INDEXED;
		{operand1, operand2, accValue} = '0;
		idxValue = 8'hF0;
		foreach (mem[i]) mem[i] = 8'h00;
		repeat (3) @(negedge sys_clk);
		resetn = 1'b1;
		t_src_idx();
		t_dst();
		t_imm();
		t_move();
		t_indirect();
		t_reset();
		wrap_up();
	end
endmodule : opadr_unit_bench

`default_nettype wire

// ### opadr_unit_monitor.sv
// Assertion checker for the operand addressing unit.
// Assumes it is bound to opadr_unit and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module opadr_unit_monitor (
	input wire logic                   sys_clk,
	input wire logic                   resetn,
	input wire logic                   start,
	input wire logic                   busy,
	input wire logic                   isMove,
	input wire opadr_pkg::opadr_mode_e mode,
	input wire logic [7:0]             operand1,
	input wire logic [7:0]             operand2,
	input wire logic [7:0]             idxValue,
	input wire logic [7:0]             accValue,
	input wire logic [7:0]             ramRdData,
	input wire logic [1:0]             instrLen,
	input wire logic [7:0]             srcAddr,
	input wire logic [7:0]             dstAddr,
	input wire logic [7:0]             immValue,
	input wire logic                   illegal,
	input wire logic                   done,
	input wire logic                   ramRd,
	input wire logic                   ramWr,
	input wire logic [7:0]             ramAddr,
	input wire logic [7:0]             ramWrData,
	input wire logic                   accLoad,
	input wire logic [7:0]             accLoadData
);
	import opadr_pkg::*;

	// ----------------------------------------------------------------
	// Accepted request; a start while busy is not a new instruction
	// ----------------------------------------------------------------
	logic go;
	assign go = start && !busy;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_src_idx_sum: assert property (go && mode == OPADR_SRC_INDEXED |=>
		srcAddr == 8'($past(operand1) + $past(idxValue)) && instrLen == LEN_TWO)
		else $error("source indexed address or length wrong");
	a_dst_direct: assert property (go && mode == OPADR_DST_DIRECT |=>
		dstAddr == $past(operand1) && instrLen == LEN_TWO)
		else $error("destination direct address wrong");
	a_dst_idx_sum: assert property (go && mode == OPADR_DST_INDEXED |=>
		dstAddr == 8'($past(operand1) + $past(idxValue)))
		else $error("destination indexed address wrong");
	a_dir_imm: assert property (go && mode == OPADR_DST_DIR_IMM |=>
		dstAddr == $past(operand1) && immValue == $past(operand2) && instrLen == LEN_THREE)
		else $error("direct immediate decode wrong");
	a_idx_imm: assert property (go && mode == OPADR_DST_IDX_IMM |=>
		dstAddr == 8'($past(operand1) + $past(idxValue)) && immValue == $past(operand2))
		else $error("indexed immediate decode wrong");
	a_move_copy: assert property (go && mode == OPADR_MEM_TO_MEM && isMove |=>
		ramRd && ramAddr == $past(operand2) ##1
		ramWr && ramAddr == $past(operand1, 2) && ramWrData == ramRdData ##1 done)
		else $error("memory move sequence wrong");
	a_move_refused: assert property (go && mode == OPADR_MEM_TO_MEM && !isMove |=>
		illegal ##0 (!ramRd && !ramWr) [*3])
		else $error("memory move without move opcode not refused");
	a_ind_refused: assert property (go && !isMove &&
		(mode == OPADR_SRC_INDIRECT || mode == OPADR_DST_INDIRECT) |=>
		illegal ##0 (!ramRd && !ramWr) [*3])
		else $error("indirect mode without move opcode not refused");
	a_src_ind_walk: assert property (go && mode == OPADR_SRC_INDIRECT && isMove |=>
		ramRd && ramAddr == $past(operand1) ##1 ramRd && ramAddr == ramRdData ##1
		ramWr && ramAddr == $past(operand1, 3) &&
		ramWrData == 8'($past(ramRdData) + PTR_STEP) ##1
		done && accLoad && accLoadData == $past(ramRdData))
		else $error("indirect load sequence wrong");
	a_dst_ind_walk: assert property (go && mode == OPADR_DST_INDIRECT && isMove |=>
		ramRd && ramAddr == $past(operand1) ##1
		ramWr && ramAddr == ramRdData && ramWrData == accValue ##1
		ramWr && ramAddr == $past(operand1, 3) &&
		ramWrData == 8'($past(ramRdData) + PTR_STEP) ##1 done)
		else $error("indirect store sequence wrong");
endmodule : opadr_unit_monitor

bind opadr_unit opadr_unit_monitor opadr_unit_monitor_inst (
	.sys_clk(sys_clk), .resetn(resetn), .start(start), .busy(busy), .isMove(isMove),
	.mode(mode), .operand1(operand1), .operand2(operand2), .idxValue(idxValue),
	.accValue(accValue), .ramRdData(ramRdData), .instrLen(instrLen),
	.srcAddr(srcAddr), .dstAddr(dstAddr), .immValue(immValue), .illegal(illegal),
	.done(done), .ramRd(ramRd), .ramWr(ramWr), .ramAddr(ramAddr),
	.ramWrData(ramWrData), .accLoad(accLoad), .accLoadData(accLoadData));

`default_nettype wire
